// File: drsm_pkg.sv
// shared constants and types for the display rail sequencer monitor
package drsm_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_MHZ = 125;
	localparam int unsigned DISCHARGE_MS = 100;
	localparam int unsigned DISCHARGE_CYC = DISCHARGE_MS * 1000 * CLK_MHZ;
	localparam int unsigned STEP_DELAY_CYC = 16;

	// ----------------------------------------------------------------
	// rail indices
	// ----------------------------------------------------------------
	localparam int unsigned NUM_RAILS = 4;
	localparam int unsigned RAIL_GATE_HIGH = 0;
	localparam int unsigned RAIL_GATE_LOW = 1;
	localparam int unsigned RAIL_SRC_POS = 2;
	localparam int unsigned RAIL_SRC_NEG = 3;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [3:0] RAIL_EN_RST = 4'hf;
	localparam logic [7:0] TEMP_RST = 8'h00;
	localparam logic [7:0] HOT_RST = 8'h8c;
	localparam logic [7:0] COLD_RST = 8'h00;
	localparam logic [7:0] DELTA_RST = 8'h02;
	localparam logic [7:0] UP_ORDER_RST = 8'he4;
	localparam logic [7:0] DOWN_ORDER_RST = 8'h1b;

	typedef enum logic [2:0] {
		DRSM_OFF = 3'b000,
		DRSM_IDLE = 3'b001,
		DRSM_UP = 3'b010,
		DRSM_ACTIVE = 3'b011,
		DRSM_DOWN = 3'b100,
		DRSM_DISCHARGE = 3'b101
	} drsm_state_t;

	// host configuration bundle
	typedef struct packed {
		logic [3:0] rail_enable;
		logic [7:0] up_order;
		logic [7:0] down_order;
		logic [7:0] hot_limit;
		logic [7:0] cold_limit;
		logic [7:0] delta_limit;
	} drsm_cfg_t;

	// temperature conversion result
	typedef struct packed {
		logic valid;
		logic [7:0] value;
	} drsm_temp_t;

endpackage : drsm_pkg

// File: drsm_edge_sync.sv
// request pin synchroniser with edge detect
`timescale 1ns/1ns
module drsm_edge_sync (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic pin,
	output logic level,
	output logic rise,
	output logic fall
);
	logic meta_q, meta_d;
	logic sync_q, sync_d;
	logic prev_q, prev_d;

	always_comb
	begin
		meta_d = pin;
		sync_d = meta_q;
		prev_d = sync_q;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
		end
		else
		begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			prev_q <= prev_d;
		end
	end

	assign level = sync_q;
	assign rise = sync_q & ~prev_q;
	assign fall = ~sync_q & prev_q;

	a_rise_timing: assert property (@(posedge sys_clk) disable iff (rst)
		rise |-> $past(pin, 2) && !$past(pin, 3))
		else $error("rise pulse does not follow synchronised pin");
endmodule : drsm_edge_sync

// File: drsm_temp_mon.sv
// temperature reading store and threshold compare
`timescale 1ns/1ns
module drsm_temp_mon (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clear,
	input drsm_pkg::drsm_temp_t conv,
	input wire logic baseline_load,
	input drsm_pkg::drsm_cfg_t cfg,
	output logic [7:0] reading,
	output logic hot_irq,
	output logic cold_irq,
	output logic delta_irq
);
	logic [7:0] reading_d, reading_q;
	logic [7:0] base_d, base_q;
	logic hot_d, hot_q, cold_d, cold_q, delta_d, delta_q;
	logic [7:0] diff;

	always_comb
	begin
		reading_d = reading_q;
		base_d = base_q;
		hot_d = 1'b0;
		cold_d = 1'b0;
		delta_d = 1'b0;
		diff = (conv.value >= base_q) ? conv.value - base_q : base_q - conv.value;
		if (clear)
		begin
			reading_d = drsm_pkg::TEMP_RST;
			base_d = drsm_pkg::TEMP_RST;
		end
		else
		begin
			if (conv.valid)
			begin
				reading_d = conv.value;
				hot_d = conv.value > cfg.hot_limit;
				cold_d = conv.value < cfg.cold_limit;
				delta_d = diff > cfg.delta_limit;
			end
			if (baseline_load)
				base_d = reading_q;
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			reading_q <= drsm_pkg::TEMP_RST;
			base_q <= drsm_pkg::TEMP_RST;
			hot_q <= 1'b0;
			cold_q <= 1'b0;
			delta_q <= 1'b0;
		end
		else
		begin
			reading_q <= reading_d;
			base_q <= base_d;
			hot_q <= hot_d;
			cold_q <= cold_d;
			delta_q <= delta_d;
		end
	end

	assign reading = reading_q;
	assign hot_irq = hot_q;
	assign cold_irq = cold_q;
	assign delta_irq = delta_q;

	a_reading_latest: assert property (@(posedge sys_clk) disable iff (rst)
		conv.valid && !clear |=> reading_q == $past(conv.value))
		else $error("reading not updated");
	a_hot_cause: assert property (@(posedge sys_clk) disable iff (rst)
		conv.valid && !clear && conv.value > cfg.hot_limit |=> hot_q)
		else $error("hot interrupt missing");
	a_cold_cause: assert property (@(posedge sys_clk) disable iff (rst)
		conv.valid && !clear && conv.value < cfg.cold_limit |=> cold_q)
		else $error("cold interrupt missing");
	a_delta_source: assert property (@(posedge sys_clk) disable iff (rst)
		!conv.valid |=> !delta_q)
		else $error("delta interrupt without conversion");
endmodule : drsm_temp_mon

// File: drsm_top.sv
// display rail sequencer and monitor: power states, rails-ok, temperature
`timescale 1ns/1ns
module drsm_top #(
	parameter int unsigned DISCHARGE_CYCLES = drsm_pkg::DISCHARGE_CYC
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic wake_request_pin,
	input wire logic power_up_request_pin,
	input wire logic cfg_write,
	input drsm_pkg::drsm_cfg_t cfg_in,
	input wire logic active_cmd,
	input wire logic standby_cmd,
	input drsm_pkg::drsm_temp_t temp_conv,
	input wire logic baseline_load,
	input wire logic [3:0] rail_regulating,
	input wire logic [3:0] rail_fault,
	output logic [3:0] rail_on,
	output logic negative_boost_converter_on,
	output logic rails_ok_output_o,
	output logic rails_ok_output_oe,
	output logic host_port_enabled,
	output logic [2:0] power_state,
	output logic [7:0] temperature_reading,
	output logic temp_hot_irq,
	output logic temp_cold_irq,
	output logic temp_delta_irq
);
	// ----------------------------------------------------------------
	// request pins
	// ----------------------------------------------------------------
	logic wake_lvl, wake_rise, wake_fall;
	logic pwr_lvl, pwr_rise, pwr_fall;

	drsm_edge_sync u_wake (
		.sys_clk(sys_clk),
		.rst(rst),
		.pin(wake_request_pin),
		.level(wake_lvl),
		.rise(wake_rise),
		.fall(wake_fall)
	);

	drsm_edge_sync u_pwr (
		.sys_clk(sys_clk),
		.rst(rst),
		.pin(power_up_request_pin),
		.level(pwr_lvl),
		.rise(pwr_rise),
		.fall(pwr_fall)
	);

	// ----------------------------------------------------------------
	// sequencer state
	// ----------------------------------------------------------------
	drsm_pkg::drsm_state_t state_q, state_d;
	drsm_pkg::drsm_cfg_t cfg_q, cfg_d;
	logic [1:0] step_q, step_d;
	logic [31:0] cnt_q, cnt_d;
	logic [3:0] rail_q, rail_d;
	logic boost_q, boost_d;
	logic up_pend_q, up_pend_d;
	logic ok_q, ok_d;
	logic port_q, port_d;
	logic [1:0] up_idx, dn_idx;
	logic in_off;

	assign up_idx = cfg_q.up_order[2*step_q +: 2];
	assign dn_idx = cfg_q.down_order[2*step_q +: 2];
	assign in_off = (state_q == drsm_pkg::DRSM_OFF);

	always_comb
	begin
		state_d = state_q;
		step_d = step_q;
		cnt_d = (cnt_q != 32'h0) ? cnt_q - 32'h1 : 32'h0;
		rail_d = rail_q;
		boost_d = boost_q;
		up_pend_d = up_pend_q;
		case (state_q)
			drsm_pkg::DRSM_OFF:
			begin
				rail_d = 4'h0;
				boost_d = 1'b0;
				if (wake_rise && pwr_lvl)
				begin
					state_d = drsm_pkg::DRSM_UP;
					step_d = 2'd0;
					boost_d = 1'b1;
					cnt_d = drsm_pkg::STEP_DELAY_CYC;
				end
				else if (wake_lvl)
					state_d = drsm_pkg::DRSM_IDLE;
			end
			drsm_pkg::DRSM_IDLE:
			begin
				if (!wake_lvl)
					state_d = drsm_pkg::DRSM_OFF;
				else if (pwr_rise || active_cmd)
				begin
					state_d = drsm_pkg::DRSM_UP;
					step_d = 2'd0;
					boost_d = 1'b1;
					cnt_d = drsm_pkg::STEP_DELAY_CYC;
				end
			end
			drsm_pkg::DRSM_UP:
			begin
				// aborting mid-sequence goes straight to power-down
				if (!wake_lvl || pwr_fall || standby_cmd)
				begin
					state_d = drsm_pkg::DRSM_DOWN;
					step_d = 2'd0;
					cnt_d = drsm_pkg::STEP_DELAY_CYC;
				end
				else if (cnt_q == 32'h0)
				begin
					// host rail enable gates each strobe
					rail_d[up_idx] = cfg_q.rail_enable[up_idx];
					step_d = step_q + 2'd1;
					cnt_d = drsm_pkg::STEP_DELAY_CYC;
					if (step_q == 2'd3)
						state_d = drsm_pkg::DRSM_ACTIVE;
				end
			end
			drsm_pkg::DRSM_ACTIVE:
			begin
				rail_d = cfg_q.rail_enable;
				if (!wake_lvl || pwr_fall || standby_cmd)
				begin
					state_d = drsm_pkg::DRSM_DOWN;
					step_d = 2'd0;
					cnt_d = drsm_pkg::STEP_DELAY_CYC;
				end
			end
			drsm_pkg::DRSM_DOWN:
			begin
				// a new power-up request is served after the down sequence if wake is still high, else dropped at the discharge end
				if (pwr_rise || active_cmd)
					up_pend_d = 1'b1;
				if (cnt_q == 32'h0)
				begin
					rail_d[dn_idx] = 1'b0;
					step_d = step_q + 2'd1;
					cnt_d = drsm_pkg::STEP_DELAY_CYC;
					if (step_q == 2'd3)
					begin
						state_d = drsm_pkg::DRSM_DISCHARGE;
						cnt_d = DISCHARGE_CYCLES;
					end
				end
			end
			drsm_pkg::DRSM_DISCHARGE:
			begin
				if (up_pend_q && wake_lvl)
				begin
					up_pend_d = 1'b0;
					state_d = drsm_pkg::DRSM_UP;
					step_d = 2'd0;
					cnt_d = drsm_pkg::STEP_DELAY_CYC;
				end
				else if (cnt_q == 32'h0)
				begin
					boost_d = 1'b0;
					up_pend_d = 1'b0;
					state_d = wake_lvl ? drsm_pkg::DRSM_IDLE : drsm_pkg::DRSM_OFF;
				end
			end
			default:
				state_d = drsm_pkg::DRSM_OFF;
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			state_q <= drsm_pkg::DRSM_OFF;
			step_q <= 2'd0;
			cnt_q <= 32'h0;
			rail_q <= 4'h0;
			boost_q <= 1'b0;
			up_pend_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			step_q <= step_d;
			cnt_q <= cnt_d;
			rail_q <= rail_d;
			boost_q <= boost_d;
			up_pend_q <= up_pend_d;
		end
	end

	// ----------------------------------------------------------------
	// host settings and status
	// ----------------------------------------------------------------
	always_comb
	begin
		cfg_d = cfg_q;
		// deep-off holds reset and ignores writes
		if (in_off)
		begin
			cfg_d.rail_enable = drsm_pkg::RAIL_EN_RST;
			cfg_d.up_order = drsm_pkg::UP_ORDER_RST;
			cfg_d.down_order = drsm_pkg::DOWN_ORDER_RST;
			cfg_d.hot_limit = drsm_pkg::HOT_RST;
			cfg_d.cold_limit = drsm_pkg::COLD_RST;
			cfg_d.delta_limit = drsm_pkg::DELTA_RST;
		end
		else if (cfg_write)
			cfg_d = cfg_in;
		ok_d = &(rail_q & rail_regulating & ~rail_fault & cfg_q.rail_enable);
		// port flag is registered from the next state, so it is never a cycle late
		port_d = (state_d != drsm_pkg::DRSM_OFF);
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			cfg_q <= '{drsm_pkg::RAIL_EN_RST, drsm_pkg::UP_ORDER_RST, drsm_pkg::DOWN_ORDER_RST,
				drsm_pkg::HOT_RST, drsm_pkg::COLD_RST, drsm_pkg::DELTA_RST};
			ok_q <= 1'b0;
			port_q <= 1'b0;
		end
		else
		begin
			cfg_q <= cfg_d;
			ok_q <= ok_d;
			port_q <= port_d;
		end
	end

	// ----------------------------------------------------------------
	// temperature
	// ----------------------------------------------------------------
	drsm_pkg::drsm_temp_t conv_gated;
	always_comb
	begin
		conv_gated = temp_conv;
		conv_gated.valid = temp_conv.valid && !in_off;
	end

	drsm_temp_mon u_temp (
		.sys_clk(sys_clk),
		.rst(rst),
		.clear(in_off),
		.conv(conv_gated),
		.baseline_load(baseline_load && !in_off),
		.cfg(cfg_q),
		.reading(temperature_reading),
		.hot_irq(temp_hot_irq),
		.cold_irq(temp_cold_irq),
		.delta_irq(temp_delta_irq)
	);

	assign rail_on = rail_q;
	assign negative_boost_converter_on = boost_q;
	assign rails_ok_output_o = 1'b0;
	assign rails_ok_output_oe = ~ok_q;
	assign host_port_enabled = port_q;
	assign power_state = state_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_last_down;
		state_q == drsm_pkg::DRSM_DOWN && state_d == drsm_pkg::DRSM_DISCHARGE;
	endsequence

	a_up_start: assert property (@(posedge sys_clk) disable iff (rst)
		state_q == drsm_pkg::DRSM_IDLE && pwr_rise && wake_lvl |=> state_q == drsm_pkg::DRSM_UP)
		else $error("power-up edge not taken");
	a_wake_down: assert property (@(posedge sys_clk) disable iff (rst)
		state_q == drsm_pkg::DRSM_ACTIVE && !wake_lvl |=> state_q == drsm_pkg::DRSM_DOWN)
		else $error("wake low did not power down");
	a_off_entry: assert property (@(posedge sys_clk) disable iff (rst)
		state_q == drsm_pkg::DRSM_DISCHARGE && state_d == drsm_pkg::DRSM_OFF |-> cnt_q == 32'h0)
		else $error("deep-off before discharge end");
	a_wake_direct: assert property (@(posedge sys_clk) disable iff (rst)
		in_off && wake_rise && pwr_lvl |=> state_q == drsm_pkg::DRSM_UP)
		else $error("direct wake to power-up missing");
	a_ok_low: assert property (@(posedge sys_clk) disable iff (rst)
		!(&(rail_regulating & ~rail_fault & rail_q)) |=> rails_ok_output_oe)
		else $error("rails-ok released with bad rail");
	a_ok_disabled: assert property (@(posedge sys_clk) disable iff (rst)
		!(&cfg_q.rail_enable) |=> rails_ok_output_oe)
		else $error("rails-ok released with disabled rail");
	a_boost_hold: assert property (@(posedge sys_clk) disable iff (rst)
		s_last_down |=> negative_boost_converter_on [*8])
		else $error("boost off during discharge");
	a_idle_port: assert property (@(posedge sys_clk) disable iff (rst)
		state_q == drsm_pkg::DRSM_IDLE |-> host_port_enabled)
		else $error("idle without port");
	a_off_reset: assert property (@(posedge sys_clk) disable iff (rst)
		in_off ##1 in_off |-> cfg_q.rail_enable == drsm_pkg::RAIL_EN_RST && !host_port_enabled)
		else $error("deep-off settings not at reset");
endmodule : drsm_top

// File: drsm_rail_model.sv
// rail status model standing in for the four regulated output rails
`timescale 1ns/1ns
module drsm_rail_model (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic slow,
	input wire logic [3:0] rail_on,
	input wire logic [3:0] fault_req,
	output logic [3:0] rail_regulating,
	output logic [3:0] rail_fault
);
	// ----------------------------------------------------------------
	// settling delay line
	// ----------------------------------------------------------------
	logic [3:0] stage_q [8];

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 0; i < 8; i++)
				stage_q[i] <= 4'h0;
		end
		else
		begin
			stage_q[0] <= rail_on;
			for (int i = 1; i < 8; i++)
				stage_q[i] <= stage_q[i - 1] & rail_on;
		end
	end

	// a rail that is switched off drops out of regulation at once
	assign rail_regulating = (slow ? stage_q[7] : stage_q[0]) & rail_on & ~fault_req;
	assign rail_fault = fault_req & rail_on;
endmodule : drsm_rail_model

// File: tb_display_rail_sequencer_monitor.sv
// self-checking testbench for the display rail sequencer monitor
`timescale 1ns/1ns
module tb_display_rail_sequencer_monitor;
	localparam int unsigned DIS = 50;
	logic sys_clk, rst, wake, pwr, cfg_write, baseline_load, slow, active_cmd, standby_cmd;
	logic [3:0] fault_req, rail_regulating, rail_fault, rail_on;
	drsm_pkg::drsm_cfg_t cfg_in;
	drsm_pkg::drsm_temp_t temp_conv;
	logic boost_on, ok_o, ok_oe, port_en, hot, cold, delta;
	logic [2:0] power_state;
	logic [7:0] reading;
	int num_errors = 0;
	int compares = 0;

	drsm_top #(.DISCHARGE_CYCLES(DIS)) uut (.sys_clk(sys_clk), .rst(rst),
		.wake_request_pin(wake), .power_up_request_pin(pwr), .cfg_write(cfg_write),
		.cfg_in(cfg_in), .active_cmd(active_cmd), .standby_cmd(standby_cmd),
		.temp_conv(temp_conv),
		.baseline_load(baseline_load), .rail_regulating(rail_regulating),
		.rail_fault(rail_fault), .rail_on(rail_on), .negative_boost_converter_on(boost_on),
		.rails_ok_output_o(ok_o), .rails_ok_output_oe(ok_oe), .host_port_enabled(port_en),
		.power_state(power_state), .temperature_reading(reading), .temp_hot_irq(hot),
		.temp_cold_irq(cold), .temp_delta_irq(delta));

	drsm_rail_model rails (.sys_clk(sys_clk), .rst(rst), .slow(slow), .rail_on(rail_on),
		.fault_req(fault_req), .rail_regulating(rail_regulating), .rail_fault(rail_fault));

	initial
	begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// ----------------------------------------------------------------
	// access tasks
	// ----------------------------------------------------------------
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : tick

	task automatic wait_state(input logic [2:0] exp, input int lim);
		int n;
		n = 0;
		while (power_state !== exp && n < lim)
		begin
			tick(1);
			n++;
		end
		check("power_state", {5'h00, power_state}, {5'h00, exp});
	endtask : wait_state

	task automatic write_cfg(input logic [3:0] en, input logic [7:0] hot_l,
		input logic [7:0] cold_l, input logic [7:0] delta_l);
		@(posedge sys_clk);
		cfg_in <= '{rail_enable: en, up_order: 8'he4, down_order: 8'h1b,
			hot_limit: hot_l, cold_limit: cold_l, delta_limit: delta_l};
		cfg_write <= 1'b1;
		@(posedge sys_clk);
		cfg_write <= 1'b0;
		tick(1);
	endtask : write_cfg

	// host-triggered conversion; flags are {hot, cold, delta}
	task automatic convert(input logic [7:0] v, input logic [7:0] exp_rd,
		input logic [2:0] exp_irq);
		@(posedge sys_clk);
		temp_conv <= '{valid: 1'b1, value: v};
		@(posedge sys_clk);
		temp_conv.valid <= 1'b0;
		#1;
		check("temperature_reading", reading, exp_rd);
		check("temp_irqs", {5'h00, hot, cold, delta}, {5'h00, exp_irq});
		tick(1);
		check("temp_irqs_pulse", {5'h00, hot, cold, delta}, 8'h00);
	endtask : convert

	// four strobes, each newer pattern 17 cycles after the one before
	task automatic watch_rails(input logic [15:0] seq);
		logic [3:0] last;
		int n;
		for (int i = 0; i < 4; i++)
		begin
			last = rail_on;
			n = 0;
			while (rail_on === last && n < 60)
			begin
				tick(1);
				n++;
			end
			check("rail_on", {4'h0, rail_on}, {4'h0, seq[15 - 4 * i -: 4]});
			if (i > 0)
				check("strobe_gap", n[7:0], 8'h11);
		end
	endtask : watch_rails

	task automatic print_verdict();
		if (num_errors == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict

	initial
	begin
		repeat (20000) @(posedge sys_clk);
		num_errors++;
		print_verdict();
	end

	// ----------------------------------------------------------------
	// test sequence
	// ----------------------------------------------------------------
	initial
	begin
		int n;
		rst = 1'b1;
		wake = 1'b0;
		pwr = 1'b0;
		cfg_write = 1'b0;
		active_cmd = 1'b0;
		standby_cmd = 1'b0;
		baseline_load = 1'b0;
		slow = 1'b0;
		fault_req = 4'h0;
		cfg_in = '0;
		temp_conv = '0;
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		tick(2);
		check("deep_off", {3'h0, power_state, ok_oe, port_en}, 8'h02);
		write_cfg(4'h0, 8'h00, 8'hff, 8'h00);
		convert(8'h20, 8'h00, 3'b000);
		@(posedge sys_clk);
		wake <= 1'b1;
		wait_state(3'h1, 10);
		check("host_port_enabled", {7'h00, port_en}, 8'h01);
		// host ready delay before using the port
		tick(20);
		write_cfg(4'hf, 8'h50, 8'h10, 8'h05);
		@(posedge sys_clk);
		pwr <= 1'b1;
		wait_state(3'h2, 10);
		watch_rails(16'h137f);
		wait_state(3'h3, 30);
		tick(3);
		check("rails_ok", {6'h00, ok_oe, ok_o}, 8'h00);
		@(posedge sys_clk);
		fault_req <= 4'h4;
		tick(2);
		// a faulted rail pulls rails-ok low
		check("rails_ok_fault", {7'h00, ok_oe}, 8'h01);
		@(posedge sys_clk);
		fault_req <= 4'h0;
		tick(3);
		check("rails_ok_clear", {7'h00, ok_oe}, 8'h00);
		write_cfg(4'h7, 8'h50, 8'h10, 8'h05);
		tick(2);
		check("rail_on_disable", {4'h0, rail_on}, 8'h07);
		check("rails_ok_disabled", {7'h00, ok_oe}, 8'h01);
		slow <= 1'b1;
		write_cfg(4'hf, 8'h50, 8'h10, 8'h05);
		tick(2);
		// still low while the rail settles
		check("rail_on_enable", {4'h0, rail_on}, 8'h0f);
		check("rails_ok_settling", {7'h00, ok_oe}, 8'h01);
		tick(12);
		check("rails_ok_settled", {7'h00, ok_oe}, 8'h00);
		convert(8'h60, 8'h60, 3'b101);
		convert(8'h08, 8'h08, 3'b011);
		convert(8'h30, 8'h30, 3'b001);
		@(posedge sys_clk);
		baseline_load <= 1'b1;
		@(posedge sys_clk);
		baseline_load <= 1'b0;
		// change of exactly the limit stays quiet
		convert(8'h35, 8'h35, 3'b000);
		convert(8'h36, 8'h36, 3'b001);
		@(posedge sys_clk);
		slow <= 1'b0;
		wake <= 1'b0;
		wait_state(3'h4, 10);
		watch_rails(16'h7310);
		wait_state(3'h5, 30);
		n = 0;
		while (power_state === 3'h5 && n < 200)
		begin
			check("boost_on", {7'h00, boost_on}, 8'h01);
			tick(1);
			n++;
		end
		// no deep-off before the discharge delay ends
		check("discharge_long", {7'h00, n >= DIS}, 8'h01);
		check("off_after", {3'h0, power_state, boost_on, ok_oe}, 8'h01);
		check("port_off", {7'h00, port_en}, 8'h00);
		// reading cleared one cycle into deep-off
		tick(1);
		check("reading_reset", reading, 8'h00);
		@(posedge sys_clk);
		wake <= 1'b1;
		n = 0;
		while (power_state === 3'h0 && n < 10)
		begin
			tick(1);
			n++;
		end
		check("wake_to_up", {5'h00, power_state}, 8'h02);
		wait_state(3'h3, 120);
		@(posedge sys_clk);
		standby_cmd <= 1'b1;
		@(posedge sys_clk);
		standby_cmd <= 1'b0;
		wait_state(3'h4, 3);
		@(posedge sys_clk);
		active_cmd <= 1'b1;
		@(posedge sys_clk);
		active_cmd <= 1'b0;
		wait_state(3'h5, 80);
		tick(1);
		check("pend_up", {4'h0, power_state, boost_on}, 8'h05);
		wait_state(3'h3, 80);
		print_verdict();
	end
endmodule : tb_display_rail_sequencer_monitor
